// File: core/rrp_pkg.sv
// Purpose: Shared constants and types for the braking resistor protection block
// Assumes: 200 MHz clock, 32-bit plain register port
// Notes: Register offsets are byte addresses of aligned words

package rrp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SHORT_WIN_MS = 100;
    localparam int LONG_WIN_MS = 5000;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_RES_SEL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_TRIP_SEL = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_INPUTS = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_SHORT_THR = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_LONG_THR = 5'h1c;
    localparam int CTRL_ALARM_RESET_BIT = 0;

    localparam logic [1:0] RES_SEL_RST = 2'h0;
    localparam logic [7:0] TRIP_SEL_RST = 8'h00;
    localparam logic [15:0] THR_RST = 16'hffff;
    localparam logic [2:0] MASK_RST = 3'h0;

    // ------------------------------------------------------------
    // Setting codes
    // ------------------------------------------------------------
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_BUILTIN = 2'h1;
    localparam logic [1:0] RES_EXTERNAL = 2'h2;

    // Trip on input n off: base + (n - 1), input 1..6
    localparam logic [7:0] TRIP_OFF_BASE = 8'h08;
    localparam logic [7:0] TRIP_ON_INPUT6_LOW = 8'h0d;
    localparam int NUM_INPUTS = 6;

    localparam logic [7:0] ALM_CODE_NONE = 8'h00;
    localparam logic [7:0] ALM_CODE_OVERLOAD = 8'h2b;
    localparam logic [7:0] ALM_CODE_OVERHEAT = 8'h36;
    localparam logic [7:0] ALM_CODE_EXT_TRIP = 8'h37;

    typedef struct packed {
        logic ext_trip;
        logic overheat;
        logic overload;
    } rrp_alarm_t;

endpackage : rrp_pkg

// File: core/rrp_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels
// Notes: First stage feeds only the second stage

module rrp_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : rrp_sync

// File: core/rrp_window_det.sv
// Purpose: Counts ticks while absorbed power stays above a threshold
// Assumes: tick_i is a one-cycle enable pulse
// Notes: A single sample at or below threshold restarts the window

module rrp_window_det #(
    parameter int LIMIT = 100
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic en_i,
    input wire logic over_i,
    output logic fire_o
);

    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(LIMIT);

    logic [CW-1:0] count_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_ff <= '0;
        end else if (!en_i || !over_i) begin
            count_ff <= '0;
        end else if (tick_i && count_ff != CNT_MAX) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign fire_o = en_i && over_i && (count_ff == CNT_MAX);

endmodule : rrp_window_det

// File: core/rrp_top.sv
// Purpose: Braking resistor protection alarms: overload, overheat, external trip
// Assumes: Power estimate arrives on clk_i; general inputs are async pins
// Notes: Alarms hold until an alarm reset is written after their cause is gone

// Summary of operation
// - Any of six inputs selectable as trip source
// - Code 0DH trips when input six off
// - Thermostat open raises external trip alarm 55
// - Short-window high absorption raises alarm 43
// - Long over-allowable absorption raises alarm 54
// - Active external trip immediately raises alarm 55
// - Selection code enables alarms 43 and 54
// - Trip monitored only with external resistor assigned
module rrp_top
    import rrp_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int SHORT_MS = SHORT_WIN_MS,
    parameter int LONG_MS = LONG_WIN_MS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM_INPUTS-1:0] general_input_i,
    input wire logic [15:0] regen_power_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output rrp_alarm_t alarm_o,
    output logic [7:0] alarm_code_o,
    output logic irq_o
);

    localparam int TW = $clog2(TICK_CYC);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [1:0] res_sel_ff;
    logic [7:0] trip_sel_ff;
    logic [15:0] short_thr_ff;
    logic [15:0] long_thr_ff;
    logic [2:0] status_ff;
    logic [2:0] mask_ff;
    rrp_alarm_t alarm_ff;
    rrp_alarm_t nxt_alarm;
    logic [7:0] code_ff;
    logic [7:0] nxt_code;
    logic [31:0] rdata_ff;
    logic [TW-1:0] tick_cnt_ff;
    logic tick;
    logic [NUM_INPUTS-1:0] in_sync;
    logic alarm_reset;
    logic en_overload;
    logic en_overheat;
    logic trip_assigned;
    logic [7:0] trip_offset;
    logic [2:0] trip_idx;
    logic trip_active;
    logic short_fire;
    logic long_fire;
    rrp_alarm_t cause;
    rrp_alarm_t raise;

    // ------------------------------------------------------------
    // Input synchroniser and millisecond tick
    // ------------------------------------------------------------
    rrp_sync #(
        .WIDTH(NUM_INPUTS)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(general_input_i),
        .sync_o(in_sync)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_ff <= '0;
        end else if (tick_cnt_ff == TICK_LAST) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
        end
    end

    assign tick = (tick_cnt_ff == TICK_LAST);

    // ------------------------------------------------------------
    // Alarm enables from resistor selection
    // ------------------------------------------------------------
    assign en_overload = (res_sel_ff == RES_BUILTIN) || (res_sel_ff == RES_EXTERNAL);
    assign en_overheat = (res_sel_ff == RES_BUILTIN);

    // ------------------------------------------------------------
    // External trip source decode
    // ------------------------------------------------------------
    assign trip_offset = trip_sel_ff - TRIP_OFF_BASE;
    assign trip_assigned = (trip_sel_ff >= TRIP_OFF_BASE)
        && (trip_offset < 8'(NUM_INPUTS));
    assign trip_idx = trip_offset[2:0];
    // Off state of the assigned input means contact open
    assign trip_active = trip_assigned && !in_sync[trip_idx];

    // ------------------------------------------------------------
    // Absorption window detectors
    // ------------------------------------------------------------
    rrp_window_det #(
        .LIMIT(SHORT_MS)
    ) u_short_det (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .en_i(en_overload),
        .over_i(regen_power_i > short_thr_ff),
        .fire_o(short_fire)
    );

    rrp_window_det #(
        .LIMIT(LONG_MS)
    ) u_long_det (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .en_i(en_overheat),
        .over_i(regen_power_i > long_thr_ff),
        .fire_o(long_fire)
    );

    // ------------------------------------------------------------
    // Alarm latch
    // ------------------------------------------------------------
    always_comb begin
        cause.overload = short_fire;
        cause.overheat = long_fire;
        cause.ext_trip = trip_active && (res_sel_ff == RES_EXTERNAL);
        raise = cause & ~alarm_ff;
        // Reset clears only alarms whose cause has gone; a cause keeps it set
        nxt_alarm = (alarm_ff & ~({3{alarm_reset}} & ~cause)) | cause;
        if (nxt_alarm.ext_trip) begin
            nxt_code = ALM_CODE_EXT_TRIP;
        end else if (nxt_alarm.overload) begin
            nxt_code = ALM_CODE_OVERLOAD;
        end else if (nxt_alarm.overheat) begin
            nxt_code = ALM_CODE_OVERHEAT;
        end else begin
            nxt_code = ALM_CODE_NONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alarm_ff <= '0;
            code_ff <= ALM_CODE_NONE;
        end else begin
            alarm_ff <= nxt_alarm;
            code_ff <= nxt_code;
        end
    end

    assign alarm_o = alarm_ff;
    assign alarm_code_o = code_ff;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign alarm_reset = wr_i && (addr_i == ADDR_CTRL) && wdata_i[CTRL_ALARM_RESET_BIT];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_sel_ff <= RES_SEL_RST;
            trip_sel_ff <= TRIP_SEL_RST;
            short_thr_ff <= THR_RST;
            long_thr_ff <= THR_RST;
            mask_ff <= MASK_RST;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_RES_SEL: res_sel_ff <= wdata_i[1:0];
                ADDR_TRIP_SEL: trip_sel_ff <= wdata_i[7:0];
                ADDR_SHORT_THR: short_thr_ff <= wdata_i[15:0];
                ADDR_LONG_THR: long_thr_ff <= wdata_i[15:0];
                ADDR_MASK: mask_ff <= wdata_i[2:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event wins over a same-cycle clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_ff <= '0;
        end else if (wr_i && addr_i == ADDR_STATUS) begin
            status_ff <= (status_ff & ~wdata_i[2:0]) | raise;
        end else begin
            status_ff <= status_ff | raise;
        end
    end

    assign irq_o = |(status_ff & mask_ff);

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= '0;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_RES_SEL: rdata_ff <= {30'h0, res_sel_ff};
                ADDR_TRIP_SEL: rdata_ff <= {24'h0, trip_sel_ff};
                ADDR_CTRL: rdata_ff <= {29'h0, alarm_ff};
                ADDR_STATUS: rdata_ff <= {29'h0, status_ff};
                ADDR_MASK: rdata_ff <= {29'h0, mask_ff};
                ADDR_INPUTS: rdata_ff <= {26'h0, in_sync};
                ADDR_SHORT_THR: rdata_ff <= {16'h0, short_thr_ff};
                ADDR_LONG_THR: rdata_ff <= {16'h0, long_thr_ff};
                default: rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign rdata_o = rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_any_input_trip: assert property (
        (res_sel_ff == RES_EXTERNAL) && trip_assigned && !in_sync[trip_idx]
        |=> alarm_o.ext_trip)
        else $error("assigned input off did not raise external trip");

    a_input6_code: assert property (
        (trip_sel_ff == TRIP_ON_INPUT6_LOW) && !in_sync[5] |-> trip_active)
        else $error("input six off not seen as trip with code 0d");

    a_ext_code_out: assert property (
        alarm_o.ext_trip |-> alarm_code_o == ALM_CODE_EXT_TRIP)
        else $error("external trip alarm without code 55");

    a_overload_raise: assert property (
        short_fire && en_overload |=> alarm_o.overload && alarm_code_o != ALM_CODE_NONE)
        else $error("short window overload did not raise alarm 43");

    a_overheat_raise: assert property (
        long_fire |=> alarm_o.overheat && $past(res_sel_ff) == RES_BUILTIN)
        else $error("long window overheat did not raise alarm 54");

    // A cause that returns while the alarm is still latched raises no new event
    a_ext_immediate: assert property (
        $rose(cause.ext_trip) && !alarm_o.ext_trip |=> alarm_o.ext_trip && status_ff[2])
        else $error("external trip not flagged in the next cycle");

    a_sel_gating: assert property (
        (res_sel_ff == RES_NONE) && !alarm_o.overload && !alarm_o.overheat
        |=> !alarm_o.overload && !alarm_o.overheat)
        else $error("alarm 43 or 54 raised with no resistor selected");

    a_ext_needs_sel: assert property (
        (res_sel_ff != RES_EXTERNAL || !trip_assigned) && !alarm_o.ext_trip
        |=> !alarm_o.ext_trip)
        else $error("external trip raised without external selection");

    a_alarm_sticky: assert property (
        alarm_o.overload && !alarm_reset |=> alarm_o.overload)
        else $error("overload alarm cleared without alarm reset");

    a_ext_held_cause: assert property (
        alarm_o.ext_trip && cause.ext_trip |=> alarm_o.ext_trip)
        else $error("external trip alarm cleared while its cause stands");

    a_reset_clears: assert property (
        alarm_o.overload && alarm_reset && !cause.overload |=> !alarm_o.overload)
        else $error("overload alarm kept after reset with cause gone");

    a_ext_status_hold: assert property (
        status_ff[2] && !(wr_i && (addr_i == ADDR_STATUS) && wdata_i[2])
        |=> status_ff[2])
        else $error("external trip status bit lost without a clear");

    a_overheat_gated: assert property (
        (res_sel_ff == RES_EXTERNAL) && !alarm_o.overheat
        |=> !alarm_o.overheat)
        else $error("alarm 54 raised with external resistor selected");

    a_overload_code: assert property (
        alarm_o.overload && !alarm_o.ext_trip |-> alarm_code_o == ALM_CODE_OVERLOAD)
        else $error("overload alarm without code 43");

    a_overheat_code: assert property (
        alarm_o == 3'h2 |-> alarm_code_o == ALM_CODE_OVERHEAT)
        else $error("overheat alarm alone without code 54");

    c_overload_seen: cover property (alarm_o.overload);
    c_overheat_seen: cover property (alarm_o.overheat);
    c_ext_trip_seen: cover property ($rose(alarm_o.ext_trip));
    c_reset_clears: cover property (alarm_o.ext_trip && alarm_reset && !cause.ext_trip
        ##1 !alarm_o.ext_trip);

endmodule : rrp_top

// File: verif/rrp_thermo_model.sv
// Purpose: Normally closed thermostat contact of an external braking resistor
// Assumes: Open command changes by non-blocking assignment after a clock edge
// Notes: A closed contact reads as input on, an open contact as off

module rrp_thermo_model (
    input wire logic clk_i,
    input wire logic open_i,
    output logic contact_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Contact
    // ------------------------------------------------------------
    initial contact_o = 1'b1;

    // Contact lags the open command by one edge
    always @(posedge clk_i) begin
        contact_o <= ~open_i;
    end
endmodule : rrp_thermo_model

// File: verif/rrp_top_tb.sv
// Purpose: Self-checking bench for the braking resistor protection block
// Assumes: Short counts set by parameters: 4-cycle tick, 3 and 6 tick windows
// Notes: Unused general inputs are held on, the contact sits on one chosen pin

module rrp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rrp_pkg::*;

    localparam int TCK = 4;
    localparam int SMS = 3;
    localparam int LMS = 6;

    logic clk_i = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] power = 16'h0000;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    rrp_alarm_t alarm;
    logic [7:0] code;
    logic irq;
    logic open_cmd = 1'b0;
    logic contact;
    logic [2:0] pin_idx = 3'd5;
    logic [5:0] gen_in;
    int err_count = 0;
    int checks_done = 0;

    always #2.5 clk_i = ~clk_i;

    assign gen_in = 6'h3f & ~({5'h00, ~contact} << pin_idx);

    rrp_thermo_model i_rrp_thermo_model (.clk_i(clk_i), .open_i(open_cmd), .contact_o(contact));

    rrp_top #(.TICK_CYC(TCK), .SHORT_MS(SMS), .LONG_MS(LMS)) i_rrp_top (
        .clk_i(clk_i), .rst_n_i(rst_n), .general_input_i(gen_in), .regen_power_i(power),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .alarm_o(alarm), .alarm_code_o(code), .irq_o(irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk(what, rdata, v);
    endtask : rd_chk

    task automatic final_report;
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        rd_chk("res_sel", ADDR_RES_SEL, 32'h0);
        rd_chk("trip_sel", ADDR_TRIP_SEL, 32'h0);
        rd_chk("short_thr", ADDR_SHORT_THR, 32'h0000ffff);
        rd_chk("long_thr", ADDR_LONG_THR, 32'h0000ffff);
        rd_chk("mask", ADDR_MASK, 32'h0);
        rd_chk("unmapped", 5'h01, 32'h0);
        bus_wr(ADDR_INPUTS, 32'h0);
        rd_chk("inputs", ADDR_INPUTS, 32'h0000003f);
        @(posedge clk_i);
        #1;
        chk("rdata idle", rdata, 32'h0);

        // External trip on each input in turn
        bus_wr(ADDR_RES_SEL, {30'h0, RES_EXTERNAL});
        for (int n = 0; n < NUM_INPUTS; n++) begin
            pin_idx <= n[2:0];
            bus_wr(ADDR_TRIP_SEL, {24'h0, TRIP_OFF_BASE + n[7:0]});
            bus_wr(ADDR_MASK, 32'h0);
            cyc(4);
            open_cmd <= 1'b1;
            cyc(3);
            #1;
            chk("ext early", alarm.ext_trip, 1'b0);
            @(posedge clk_i);
            #1;
            chk("ext alarm", alarm.ext_trip, 1'b1);
            chk("ext code", code, 8'h37);
            chk("irq masked", irq, 1'b0);
            bus_wr(ADDR_MASK, 32'h4);
            #1;
            chk("irq", irq, 1'b1);
            bus_wr(ADDR_CTRL, 32'h1);
            #1;
            chk("ext held", alarm.ext_trip, 1'b1);
            open_cmd <= 1'b0;
            cyc(5);
            #1;
            chk("ext latched", alarm.ext_trip, 1'b1);
            rd_chk("status", ADDR_STATUS, 32'h4);
            bus_wr(ADDR_CTRL, 32'h1);
            bus_wr(ADDR_STATUS, 32'h4);
            #1;
            chk("ext cleared", alarm.ext_trip, 1'b0);
            chk("irq cleared", irq, 1'b0);
        end

        // Trip ignored without external resistor or assignment
        bus_wr(ADDR_RES_SEL, {30'h0, RES_BUILTIN});
        bus_wr(ADDR_TRIP_SEL, {24'h0, TRIP_ON_INPUT6_LOW});
        open_cmd <= 1'b1;
        cyc(8);
        #1;
        chk("no ext builtin", alarm.ext_trip, 1'b0);
        // Unassign first: the contact is still open on input six
        bus_wr(ADDR_TRIP_SEL, 32'h0e);
        bus_wr(ADDR_RES_SEL, {30'h0, RES_EXTERNAL});
        cyc(8);
        #1;
        chk("no ext unassigned", alarm.ext_trip, 1'b0);
        open_cmd <= 1'b0;
        cyc(4);

        // Overload and overheat per resistor selection
        bus_wr(ADDR_SHORT_THR, 32'd100);
        bus_wr(ADDR_LONG_THR, 32'd100);
        for (int s = 0; s < 3; s++) begin
            bus_wr(ADDR_RES_SEL, s);
            power <= 16'd100;
            cyc(LMS * TCK + 10);
            #1;
            chk("at threshold", alarm, 3'h0);
            power <= 16'd200;
            cyc((SMS - 1) * TCK - 2);
            #1;
            chk("overload early", alarm.overload, 1'b0);
            cyc(LMS * TCK + 10);
            #1;
            chk("overload", alarm.overload, s != 0);
            chk("overheat", alarm.overheat, s == 1);
            chk("code", code, (s != 0) ? 8'h2b : 8'h00);
            power <= 16'd0;
            cyc(4);
            #1;
            chk("power latched", alarm, {1'b0, s == 1, s != 0});
            rd_chk("power status", ADDR_STATUS, {29'h0, 1'b0, s == 1, s != 0});
            bus_wr(ADDR_CTRL, 32'h1);
            bus_wr(ADDR_STATUS, 32'h7);
            #1;
            chk("power cleared", {code, 5'h0, alarm}, 16'h0);
            rd_chk("status cleared", ADDR_STATUS, 32'h0);
        end
        final_report();
    end
endmodule : rrp_top_tb
